// ==== src/io_port_regs.vh ====
// Register offsets, field positions and reset values for the I/O port block
`ifndef IO_PORT_REGS_VH
`define IO_PORT_REGS_VH

// Register bus widths
`define ADDR_W        4
`define DATA_W        8

// Register offsets (byte addresses on the plain port)
`define OFS_A_LATCH   4'h0
`define OFS_A_DIR     4'h1
`define OFS_A_SAMPLE  4'h2
`define OFS_B_LATCH   4'h3
`define OFS_B_DIR     4'h4
`define OFS_B_SAMPLE  4'h5
`define OFS_C_LATCH   4'h6
`define OFS_C_DIR     4'h7
`define OFS_C_SAMPLE  4'h8
`define OFS_D_LATCH   4'h9
`define OFS_D_DIR     4'hA
`define OFS_D_SAMPLE  4'hB
`define OFS_G_LATCH   4'hC
`define OFS_G_DIR     4'hD
`define OFS_G_SAMPLE  4'hE
`define OFS_ALT_CTRL  4'hF

// Port indices of the register array
`define PORT_A        2'h0
`define PORT_B        2'h1
`define PORT_C        2'h2
`define PORT_D        2'h3

// Reset values
`define RST_LATCH     8'h00
`define RST_DIR       8'h00
`define RST_SAMPLE    8'h00
`define RST_G         5'h00
`define RST_RDATA     8'h00
`define ZERO8         8'h00
`define ONES8         8'hFF

// Port G pin positions
`define G_WIDTH       5
`define G_WRITE_PIN   0
`define G_READ_PIN    1
`define G_ALE_PIN     2
`define G_OSC_OUT_PIN 3
`define G_OSC_IN_PIN  4
`define G_PAD         3'h0

// Alternate control register fields
`define CTRL_ASYNC_BIT 0
`define CTRL_XMEM_BIT  1
`define CTRL_PAD       6'h00

`endif

// ==== src/io_port_override_and_regs.v ====
// Four 8-bit GPIO ports plus port G with oscillator and memory-strobe overrides
`timescale 1ns/100ps
`include "io_port_regs.vh"

// Functional notes
// - Async timer select: G4 becomes oscillator input
// - Async timer select: G3 oscillator output, all off
// - Legacy mode forces port G alternate functions
// - Memory enable: G2 output drives address latch
// - Memory enable: G1 output drives read strobe
// - Memory enable: G0 output drives write strobe
// - Per-port output latch, read/write, resets zero
// - Per-port direction register, read/write, resets zero
// - Per-port read-only sample of pin levels
// - Legacy mode: port C push-pull outputs, zero
// - Port C legacy state holds without clock
module io_port_override_and_regs (
  // Clock and reset
  input  wire                 clock,
  input  wire                 rst_n,
  // Register port
  input  wire [`ADDR_W-1:0]   addr,
  input  wire [`DATA_W-1:0]   wdata,
  input  wire                 wr_en,
  input  wire                 rd_en,
  output reg  [`DATA_W-1:0]   rdata,
  // Mode strap
  input  wire                 legacy_mode,
  // Port A pins
  input  wire [7:0]           pa_in,
  output wire [7:0]           pa_out,
  output wire [7:0]           pa_oe_n,
  output wire [7:0]           pa_pullup,
  // Port B pins
  input  wire [7:0]           pb_in,
  output wire [7:0]           pb_out,
  output wire [7:0]           pb_oe_n,
  output wire [7:0]           pb_pullup,
  // Port C pins
  input  wire [7:0]           pc_in,
  output wire [7:0]           pc_out,
  output wire [7:0]           pc_oe_n,
  output wire [7:0]           pc_pullup,
  // Port D pins
  input  wire [7:0]           pd_in,
  output wire [7:0]           pd_out,
  output wire [7:0]           pd_oe_n,
  output wire [7:0]           pd_pullup,
  // Port G pins
  input  wire [4:0]           pg_in,
  output wire [4:0]           pg_out,
  output wire [4:0]           pg_oe_n,
  output wire [4:0]           pg_pullup,
  // External memory strobes from the memory controller
  input  wire                 mem_ale,
  input  wire                 mem_rd_n,
  input  wire                 mem_wr_n,
  // Oscillator analog paths
  output wire                 timer_osc_in,
  output wire                 timer_osc_out_sel,
  // Override state seen by the timer and memory logic
  output wire                 async_timer_clock_select,
  output wire                 external_memory_enable
);

  // Override mux: value replaces register when enable set
  // Shared by every port G pin and every override pair
  function mux_bit;
    input en;
    input ov;
    input rv;
    begin
      mux_bit = en ? ov : rv;
    end
  endfunction

  // Register storage for ports A to D
  reg  [7:0] latch_reg [0:3];   // Output data latches
  reg  [7:0] dir_reg   [0:3];   // Direction, 1 = output
  reg  [7:0] sample_reg[0:3];   // Pin samples
  // Port G storage
  reg  [4:0] g_latch_reg;       // Port G output latch
  reg  [4:0] g_dir_reg;         // Port G direction
  reg  [4:0] g_sample_reg;      // Port G pin samples
  // Alternate function control bits
  reg        async_sel_reg;     // Timer oscillator select
  reg        xmem_en_reg;       // External memory enable
  // Port C touched since reset
  reg        c_written_reg;     // Software wrote port C regs
  reg  [7:0] rdata_next;        // Read mux output
  integer    i;                 // Loop index
  // Port G digital input enable after override, read by the sampler
  wire [4:0] g_input_en;        // Low on pins handed to the oscillator

  // Effective override controls, legacy forces both on
  // Legacy only ORs into the selects, the control register keeps
  // what software wrote, so leaving legacy mode restores it
  wire async_eff = async_sel_reg | legacy_mode;
  wire xmem_eff  = xmem_en_reg   | legacy_mode;

  // Legacy default on port C, independent of clock edges
  // Reset term comes straight from the pin, so the pins settle
  // to push-pull zero even while no clock runs; the first
  // software write to the latch or direction hands over control
  wire c_legacy = legacy_mode & (~rst_n | ~c_written_reg);

  assign async_timer_clock_select = async_eff;
  assign external_memory_enable   = xmem_eff;

  // Register writes and pin sampling
  // Samples reset to zero; real pins have no defined level then,
  // so software should not trust the first sample after reset
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < 4; i = i + 1) begin
        latch_reg[i]  <= `RST_LATCH;
        dir_reg[i]    <= `RST_DIR;
        sample_reg[i] <= `RST_SAMPLE;
      end
      g_latch_reg   <= `RST_G;
      g_dir_reg     <= `RST_G;
      g_sample_reg  <= `RST_G;
      async_sel_reg <= 1'b0;
      xmem_en_reg   <= 1'b0;
      c_written_reg <= 1'b0;
    end else begin
      // Pins sampled every clock, digital input gating applied on port G only
      sample_reg[`PORT_A] <= pa_in;
      sample_reg[`PORT_B] <= pb_in;
      sample_reg[`PORT_C] <= pc_in;
      sample_reg[`PORT_D] <= pd_in;
      g_sample_reg <= pg_in & g_input_en;
      if (wr_en) begin
        case (addr)
          `OFS_A_LATCH: latch_reg[`PORT_A] <= wdata;
          `OFS_A_DIR:   dir_reg[`PORT_A]   <= wdata;
          `OFS_B_LATCH: latch_reg[`PORT_B] <= wdata;
          `OFS_B_DIR:   dir_reg[`PORT_B]   <= wdata;
          `OFS_C_LATCH: begin
            latch_reg[`PORT_C] <= wdata;
            c_written_reg      <= 1'b1;
          end
          `OFS_C_DIR: begin
            dir_reg[`PORT_C] <= wdata;
            c_written_reg    <= 1'b1;
          end
          `OFS_D_LATCH: latch_reg[`PORT_D] <= wdata;
          `OFS_D_DIR:   dir_reg[`PORT_D]   <= wdata;
          // Port G registers unreachable in legacy mode
          `OFS_G_LATCH: begin
            if (!legacy_mode) begin
              g_latch_reg <= wdata[`G_WIDTH-1:0];
            end
          end
          `OFS_G_DIR: begin
            if (!legacy_mode) begin
              g_dir_reg <= wdata[`G_WIDTH-1:0];
            end
          end
          // Both alternate selects in one register, other bits ignored
          `OFS_ALT_CTRL: begin
            async_sel_reg <= wdata[`CTRL_ASYNC_BIT];
            xmem_en_reg   <= wdata[`CTRL_XMEM_BIT];
          end
          default: begin
            // Read-only or unmapped, write ignored
          end
        endcase
      end
    end
  end

  // Read mux, data presented one cycle after the strobe
  always @* begin
    case (addr)
      `OFS_A_LATCH:  rdata_next = latch_reg[`PORT_A];
      `OFS_A_DIR:    rdata_next = dir_reg[`PORT_A];
      `OFS_A_SAMPLE: rdata_next = sample_reg[`PORT_A];
      `OFS_B_LATCH:  rdata_next = latch_reg[`PORT_B];
      `OFS_B_DIR:    rdata_next = dir_reg[`PORT_B];
      `OFS_B_SAMPLE: rdata_next = sample_reg[`PORT_B];
      `OFS_C_LATCH:  rdata_next = latch_reg[`PORT_C];
      `OFS_C_DIR:    rdata_next = dir_reg[`PORT_C];
      `OFS_C_SAMPLE: rdata_next = sample_reg[`PORT_C];
      `OFS_D_LATCH:  rdata_next = latch_reg[`PORT_D];
      `OFS_D_DIR:    rdata_next = dir_reg[`PORT_D];
      `OFS_D_SAMPLE: rdata_next = sample_reg[`PORT_D];
      // Port G reads zero in legacy mode, upper bits zero
      `OFS_G_LATCH:  rdata_next = legacy_mode ? `ZERO8 : {`G_PAD, g_latch_reg};
      `OFS_G_DIR:    rdata_next = legacy_mode ? `ZERO8 : {`G_PAD, g_dir_reg};
      `OFS_G_SAMPLE: rdata_next = legacy_mode ? `ZERO8 : {`G_PAD, g_sample_reg};
      `OFS_ALT_CTRL: rdata_next = {`CTRL_PAD, xmem_en_reg, async_sel_reg};
      default:       rdata_next = `ZERO8;
    endcase
  end

  // Read data register, zero when no read was requested
  // Data stands for exactly one cycle; unmapped addresses read zero
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `RST_RDATA;
    end else if (rd_en) begin
      rdata <= rdata_next;
    end else begin
      rdata <= `RST_RDATA;
    end
  end

  // Ports A, B and D: plain register-driven pins
  assign pa_out    = latch_reg[`PORT_A];
  assign pa_oe_n   = ~dir_reg[`PORT_A];
  assign pa_pullup = latch_reg[`PORT_A] & ~dir_reg[`PORT_A];
  assign pb_out    = latch_reg[`PORT_B];
  assign pb_oe_n   = ~dir_reg[`PORT_B];
  assign pb_pullup = latch_reg[`PORT_B] & ~dir_reg[`PORT_B];
  assign pd_out    = latch_reg[`PORT_D];
  assign pd_oe_n   = ~dir_reg[`PORT_D];
  assign pd_pullup = latch_reg[`PORT_D] & ~dir_reg[`PORT_D];

  // Port C: legacy default is push-pull zero until software writes
  assign pc_out    = c_legacy ? `ZERO8 : latch_reg[`PORT_C];
  assign pc_oe_n   = c_legacy ? `ZERO8 : ~dir_reg[`PORT_C];
  assign pc_pullup = c_legacy ? `ZERO8 : latch_reg[`PORT_C] & ~dir_reg[`PORT_C];

  // Each port G pin has four override pairs: pull-up, direction,
  // pin value and digital input. A high enable bit makes its value
  // bit replace what the registers would give; a low one leaves the
  // register path unchanged. Unused pairs stay zero so the plain
  // register behaviour falls through.
  // Port G override tables per pin
  reg  [4:0] pu_oe;   // Pull-up override enables
  reg  [4:0] pu_ov;   // Pull-up override values
  reg  [4:0] dd_oe;   // Direction override enables
  reg  [4:0] dd_ov;   // Direction override values
  reg  [4:0] pv_oe;   // Pin value override enables
  reg  [4:0] pv_ov;   // Pin value override values
  reg  [4:0] die_oe;  // Digital input override enables
  reg  [4:0] die_ov;  // Digital input override values
  wire [4:0] g_dir_eff;   // Direction after override

  // Override signal generation
  always @* begin
    pu_oe  = 5'h00;
    pu_ov  = 5'h00;
    dd_oe  = 5'h00;
    dd_ov  = 5'h00;
    pv_oe  = 5'h00;
    pv_ov  = 5'h00;
    die_oe = 5'h00;
    die_ov = 5'h00;
    // Oscillator pins: pull-up, driver and input all off
    pu_oe[`G_OSC_IN_PIN]   = async_eff;
    dd_oe[`G_OSC_IN_PIN]   = async_eff;
    die_oe[`G_OSC_IN_PIN]  = async_eff;
    pu_oe[`G_OSC_OUT_PIN]  = async_eff;
    dd_oe[`G_OSC_OUT_PIN]  = async_eff;
    die_oe[`G_OSC_OUT_PIN] = async_eff;
    // Address latch strobe output
    pu_oe[`G_ALE_PIN] = xmem_eff;
    dd_oe[`G_ALE_PIN] = xmem_eff;
    dd_ov[`G_ALE_PIN] = 1'b1;
    pv_oe[`G_ALE_PIN] = xmem_eff;
    pv_ov[`G_ALE_PIN] = mem_ale;
    // Read strobe output
    pu_oe[`G_READ_PIN] = xmem_eff;
    dd_oe[`G_READ_PIN] = xmem_eff;
    dd_ov[`G_READ_PIN] = 1'b1;
    pv_oe[`G_READ_PIN] = xmem_eff;
    pv_ov[`G_READ_PIN] = mem_rd_n;
    // Write strobe output
    pu_oe[`G_WRITE_PIN] = xmem_eff;
    dd_oe[`G_WRITE_PIN] = xmem_eff;
    dd_ov[`G_WRITE_PIN] = 1'b1;
    pv_oe[`G_WRITE_PIN] = xmem_eff;
    pv_ov[`G_WRITE_PIN] = mem_wr_n;
  end

  // Per-pin override muxing for port G
  genvar g;
  generate
    for (g = 0; g < `G_WIDTH; g = g + 1) begin : g_pin
      wire dir_b = mux_bit(dd_oe[g], dd_ov[g], g_dir_reg[g]);
      assign g_dir_eff[g]  = dir_b;
      assign g_input_en[g] = mux_bit(die_oe[g], die_ov[g], 1'b1);
      assign pg_out[g]     = mux_bit(pv_oe[g], pv_ov[g], g_latch_reg[g]);
      assign pg_oe_n[g]    = ~g_dir_eff[g];
      assign pg_pullup[g]  = mux_bit(pu_oe[g], pu_ov[g],
                                     g_latch_reg[g] & ~dir_b);
    end
  endgenerate

  // Oscillator analog paths, active only with timer select
  // Input path is gated so a floating pin cannot toggle the
  // oscillator while the pin still belongs to the port; the output
  // select tells the pad to hand its driver to the amplifier
  assign timer_osc_in      = async_eff & pg_in[`G_OSC_IN_PIN];
  assign timer_osc_out_sel = async_eff;

endmodule

// ==== dv/io_port_monitor.sv ====
// Checker of port G overrides and reset pin states
`timescale 1ns/100ps
module io_port_monitor (
  // Clock and reset
  input wire       clock,
  input wire       rst_n,
  // Mode and strobes
  input wire       legacy_mode,
  input wire       mem_ale,
  input wire       mem_rd_n,
  input wire       mem_wr_n,
  // Pins
  input wire [7:0] pa_out,
  input wire [7:0] pa_oe_n,
  input wire [7:0] pc_out,
  input wire [7:0] pc_oe_n,
  input wire [4:0] pg_in,
  input wire [4:0] pg_out,
  input wire [4:0] pg_oe_n,
  input wire [4:0] pg_pullup,
  // Override status
  input wire       timer_osc_in,
  input wire       timer_osc_out_sel,
  input wire       async_timer_clock_select,
  input wire       external_memory_enable
);
  // Short aliases of the two selects
  wire ts;
  wire xm;
  assign ts = async_timer_clock_select;
  assign xm = external_memory_enable;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_OSC_IN:
  assert property (ts |-> timer_osc_in == pg_in[4] && pg_oe_n[4] && !pg_pullup[4])
    else $error("osc input");
  AST_OSC_OUT:
  assert property (ts |-> timer_osc_out_sel && pg_oe_n[3] && !pg_pullup[3])
    else $error("osc output");
  AST_LEGACY_G:
  assert property (legacy_mode |-> ts && xm)
    else $error("legacy port G");
  AST_ALE:
  assert property (xm |-> !pg_oe_n[2] && pg_out[2] == mem_ale && !pg_pullup[2])
    else $error("latch strobe");
  AST_RD:
  assert property (xm |-> !pg_oe_n[1] && pg_out[1] == mem_rd_n && !pg_pullup[1])
    else $error("read strobe");
  AST_WR:
  assert property (xm |-> !pg_oe_n[0] && pg_out[0] == mem_wr_n && !pg_pullup[0])
    else $error("write strobe");
  AST_RST_A:
  assert property ($rose(rst_n) |-> pa_oe_n == 8'hFF && pa_out == 8'h00)
    else $error("port A reset");
  AST_LEGACY_C:
  assert property (legacy_mode && $rose(rst_n) |-> pc_oe_n == 8'h00 && pc_out == 8'h00)
    else $error("legacy port C");
endmodule

bind io_port_override_and_regs io_port_monitor i_mon (
  .clock(clock), .rst_n(rst_n), .legacy_mode(legacy_mode), .mem_ale(mem_ale),
  .mem_rd_n(mem_rd_n), .mem_wr_n(mem_wr_n), .pa_out(pa_out), .pa_oe_n(pa_oe_n),
  .pc_out(pc_out), .pc_oe_n(pc_oe_n), .pg_in(pg_in), .pg_out(pg_out),
  .pg_oe_n(pg_oe_n), .pg_pullup(pg_pullup), .timer_osc_in(timer_osc_in),
  .timer_osc_out_sel(timer_osc_out_sel),
  .async_timer_clock_select(async_timer_clock_select),
  .external_memory_enable(external_memory_enable));

// ==== dv/board_pins.sv ====
// Board model: pin levels seen at the port inputs
`timescale 1ns/100ps
module board_pins #(
  parameter W = 8
) (
  // Port side
  input  wire [W-1:0] out,
  input  wire [W-1:0] oe_n,
  input  wire [W-1:0] pu_en,
  // Board side
  input  wire [W-1:0] ext,
  output wire [W-1:0] lvl
);
  // Driven pins follow the driver, pulled pins read high, else board level
  assign lvl = (~oe_n & out) | (oe_n & (pu_en | ext));
endmodule

// ==== dv/testbench.sv ====
// Testbench: register access, port G overrides, legacy pin defaults
`timescale 1ns/100ps
`include "io_port_regs.vh"
module testbench;
  // Clock, reset and register port
  reg         clock;
  reg         rst_n;
  reg  [3:0]  addr;
  reg  [7:0]  wdata;
  reg         wr_en;
  reg         rd_en;
  wire [7:0]  rdata;
  // Mode, strobes and board drive
  reg         legacy_mode;
  reg         mem_ale;
  reg         mem_rd_n;
  reg         mem_wr_n;
  reg  [36:0] ext;
  // Pins of all ports, A in the low byte, G on top
  wire [36:0] pin_in;
  wire [36:0] pin_out;
  wire [36:0] pin_oe_n;
  wire [36:0] pin_pu;
  wire        osc_in;
  wire        osc_sel;
  wire        tsel;
  wire        xmem;
  // Bookkeeping
  integer     n_errors;
  integer     checks_done;
  integer     cycles;
  reg  [3:0]  p;

  io_port_override_and_regs i_dut (
    .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .legacy_mode(legacy_mode),
    .pa_in(pin_in[7:0]), .pa_out(pin_out[7:0]), .pa_oe_n(pin_oe_n[7:0]),
    .pa_pullup(pin_pu[7:0]), .pb_in(pin_in[15:8]), .pb_out(pin_out[15:8]),
    .pb_oe_n(pin_oe_n[15:8]), .pb_pullup(pin_pu[15:8]), .pc_in(pin_in[23:16]),
    .pc_out(pin_out[23:16]), .pc_oe_n(pin_oe_n[23:16]), .pc_pullup(pin_pu[23:16]),
    .pd_in(pin_in[31:24]), .pd_out(pin_out[31:24]), .pd_oe_n(pin_oe_n[31:24]),
    .pd_pullup(pin_pu[31:24]), .pg_in(pin_in[36:32]), .pg_out(pin_out[36:32]),
    .pg_oe_n(pin_oe_n[36:32]), .pg_pullup(pin_pu[36:32]), .mem_ale(mem_ale),
    .mem_rd_n(mem_rd_n), .mem_wr_n(mem_wr_n), .timer_osc_in(osc_in),
    .timer_osc_out_sel(osc_sel), .async_timer_clock_select(tsel),
    .external_memory_enable(xmem));

  board_pins #(.W(37)) i_board (
    .out(pin_out), .oe_n(pin_oe_n), .pu_en(pin_pu), .ext(ext), .lvl(pin_in));

  // 20 MHz clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Compare and count
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        n_errors = n_errors + 1;
      end
    end
  endtask

  // One write cycle, then an idle cycle
  task wr(input [3:0] a, input [7:0] d);
    begin
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
      @(posedge clock);
    end
  endtask

  // One read cycle, data taken 1 ns after the edge that captures it
  task rd(input [3:0] a, input [7:0] exp);
    begin
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1;
      chk(rdata, exp);
      @(posedge clock);
    end
  endtask

  // Reset pulse of five cycles
  task reset_dut;
    begin
      rst_n <= 1'b0;
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
    end
  endtask

  // Verdict and end of run
  task close_out;
    begin
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  // Hang guard
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      n_errors = n_errors + 1;
      close_out;
    end
  end

  // Main sequence
  initial begin
    n_errors = 0;
    checks_done = 0;
    cycles = 0;
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    legacy_mode = 1'b1;
    mem_ale = 1'b1;
    mem_rd_n = 1'b1;
    mem_wr_n = 1'b0;
    ext = 37'h1F5A5A5A5A;
    #1;
    chk(pin_oe_n[23:16], 8'h00);
    chk(pin_out[23:16], 8'h00);
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    wr(`OFS_G_DIR, 8'hFF);
    rd(`OFS_G_DIR, 8'h00);
    #1;
    chk({tsel, xmem}, 8'h03);
    chk(pin_oe_n[23:16], 8'h00);
    chk(pin_oe_n[36:32], 8'h18);
    chk(pin_out[34:32], 8'h06);
    chk(pin_pu[36:32], 8'h00);
    chk({osc_in, osc_sel}, 8'h03);
    @(posedge clock);
    mem_ale <= 1'b0;
    mem_rd_n <= 1'b0;
    mem_wr_n <= 1'b1;
    @(posedge clock);
    #1;
    chk(pin_out[34:32], 8'h01);
    $display("test legacy done");
    // Leave legacy mode on a clock edge, as all stimulus is
    @(posedge clock);
    legacy_mode <= 1'b0;
    reset_dut;
    for (p = 4'h0; p < 4'h4; p = p + 4'h1) begin
      rd(p * 4'h3, 8'h00);
      rd(p * 4'h3 + 4'h1, 8'h00);
      wr(p * 4'h3, 8'h33);
      wr(p * 4'h3 + 4'h1, 8'h0F);
      rd(p * 4'h3, 8'h33);
      rd(p * 4'h3 + 4'h1, 8'h0F);
      wr(p * 4'h3 + 4'h2, 8'hFF);
      rd(p * 4'h3 + 4'h2, 8'h73);
    end
    #1;
    chk(pin_oe_n[31:24], 8'hF0);
    chk(pin_out[7:0], 8'h33);
    $display("test registers done");
    @(posedge clock);
    wr(`OFS_G_DIR, 8'h1F);
    wr(`OFS_G_LATCH, 8'h15);
    #1;
    chk(pin_out[36:32], 8'h15);
    chk(pin_oe_n[36:32], 8'h00);
    @(posedge clock);
    wr(`OFS_ALT_CTRL, 8'h03);
    #1;
    chk(pin_oe_n[36:32], 8'h18);
    chk(pin_out[34:32], 8'h01);
    @(posedge clock);
    rd(`OFS_G_SAMPLE, 8'h01);
    $display("test overrides done");
    close_out;
  end
endmodule
